// file: rtc_consts.vh
// Purpose: Constants for the always-on seconds clock
// Assumes: Byte addresses on a 12-bit AXI4-Lite address
// Notes:   Offsets are byte addresses of aligned 32-bit words
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH

`define ADDR_W          12
`define CNT_W           47
`define SEC_W           32
`define FRAC_W          15
`define TRIM_W          16

`define OFF_CTRL        12'h000
`define OFF_SEC         12'h004
`define OFF_FRAC        12'h008
`define OFF_LOAD_SEC    12'h00c
`define OFF_LOAD_FRAC   12'h010
`define OFF_ALARM       12'h014
`define OFF_TRIM        12'h018
`define OFF_INT_STAT    12'h01c
`define OFF_INT_MASK    12'h020
`define SRAM_PAGE       4'h1

`define CTRL_EN_BIT     0
`define CTRL_LOAD_BIT   1
`define CTRL_ALARM_BIT  2
`define TRIM_EN_BIT     16
`define TRIM_SLOW_BIT   17

`define EV_W            3
`define EV_ALARM        0
`define EV_LOADED       1
`define EV_SECOND       2

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`define STEP_NONE       2'h0
`define STEP_ONE        2'h1
`define STEP_TWO        2'h2

`define SRAM_WORDS      64
`define SRAM_AW         6

`endif

// file: rtc_sram.v
// Purpose: 256-byte retained scratch memory, 64 words of 32 bits
// Assumes: One write port with byte enables, one registered read port
// Notes:   Contents are never reset so they survive a main-domain reset
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.vh"

module rtc_sram (
    input  wire                    clk,
    input  wire                    we,
    input  wire [3:0]              be,
    input  wire [`SRAM_AW-1:0]     waddr,
    input  wire [31:0]             wdata,
    input  wire                    re,
    input  wire [`SRAM_AW-1:0]     raddr,
    output reg  [31:0]             rdata_q
);
    reg [31:0] mem [0:`SRAM_WORDS-1];

    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_lane
            always @(posedge clk) begin
                if (we && be[b]) begin
                    mem[waddr][8*b+7:8*b] <= wdata[8*b+7:8*b];
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (re) begin
            rdata_q <= mem[raddr];
        end
    end
endmodule // rtc_sram

`default_nettype wire

// file: rtc_top.v
// Purpose: Always-on seconds clock with load, alarm, trim and scratch SRAM
// Assumes: ref_tick_in is the 32.768 kHz reference, already synchronous to clk
// Notes:   One count per rising edge of the reference; registers on AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.vh"

// Contract
// - One 47-bit counter steps once per reference cycle while enabled.
// - Upper 32 bits are whole seconds, lower 15 bits the fraction.
// - Seconds and fraction are read as two separate register accesses.
// - Clearing the enable bit stops the counter, holding its value.
// - A writable 32-bit staging register holds the seconds to load.
// - A writable 15-bit staging register holds the fraction to load.
// - Setting the load bit copies both staging registers into the counter at once.
// - Hardware clears the load bit after the copy, so software can poll it.
// - Matching the alarm time raises a wake-up request.
// - The counter keeps running while the main system is inactive.
// - A programmable trim adds or drops counts to correct crystal error.
// - 256 bytes of retained scratch SRAM, readable and writable.
// - Control and status registers sit on the always-on peripheral bus.
module rtc_top (
    input  wire                 clk,
    input  wire                 rst,
    input  wire                 ref_tick_in,
    input  wire [`ADDR_W-1:0]   s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    input  wire [`ADDR_W-1:0]   s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    output reg                  irq,
    output reg                  wake
);
    reg  [`CNT_W-1:0]   count_q;
    reg  [`SEC_W-1:0]   load_sec_q;
    reg  [`FRAC_W-1:0]  load_frac_q;
    reg  [`SEC_W-1:0]   alarm_q;
    reg  [31:0]         trim_q;
    reg  [`TRIM_W-1:0]  trim_cnt_q;
    reg                 en_q;
    reg                 load_q;
    reg                 alarm_en_q;
    reg  [`EV_W-1:0]    stat_q;
    reg  [`EV_W-1:0]    mask_q;
    reg                 ref_q;

    reg                 aw_have_q;
    reg                 w_have_q;
    reg  [`ADDR_W-1:0]  aw_addr_q;
    reg  [31:0]         w_data_q;
    reg  [3:0]          w_strb_q;
    reg                 rd_busy_q;
    reg  [`ADDR_W-1:0]  ar_addr_q;

    wire                tick;
    wire                trim_hit;
    reg  [1:0]          step;
    wire [`CNT_W-1:0]   count_d;
    wire [`FRAC_W:0]    frac_sum;
    wire                sec_wrap;
    wire                wr_fire;
    wire                rd_take;
    wire                wr_sram;
    wire                rd_sram_q;
    wire [31:0]         wmask;
    wire [31:0]         sram_rdata;
    wire [`EV_W-1:0]    ev_set;
    wire [`EV_W-1:0]    ev_clr;
    reg  [31:0]         reg_rdata;
    reg                 reg_hit;
    reg                 wr_hit;

    // Reference rising edge; the pin is already in the clk domain
    assign tick = ref_tick_in & ~ref_q;

    // Trim: every period plus one ticks, one extra count is added or one dropped
    assign trim_hit = trim_q[`TRIM_EN_BIT] && (trim_cnt_q == trim_q[`TRIM_W-1:0]);

    always @* begin
        step = `STEP_ONE;
        if (trim_hit) begin
            step = trim_q[`TRIM_SLOW_BIT] ? `STEP_NONE : `STEP_TWO;
        end
    end

    // One wide add carries the fraction wrap straight into the seconds
    assign count_d  = count_q + {{(`CNT_W-2){1'b0}}, step};
    assign frac_sum = {1'b0, count_q[`FRAC_W-1:0]} + {{(`FRAC_W-1){1'b0}}, step};
    assign sec_wrap = en_q && tick && frac_sum[`FRAC_W];

    assign wr_fire  = aw_have_q && w_have_q && !s_axi_bvalid;
    assign rd_take  = s_axi_arvalid && s_axi_arready;
    assign wr_sram  = wr_fire && (aw_addr_q[`ADDR_W-1:8] == `SRAM_PAGE);
    assign rd_sram_q = (ar_addr_q[`ADDR_W-1:8] == `SRAM_PAGE);

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_mask
            assign wmask[8*i+7:8*i] = {8{w_strb_q[i]}};
        end
    endgenerate

    assign ev_set[`EV_ALARM]  = alarm_en_q && (count_q[`CNT_W-1:`FRAC_W] == alarm_q);
    assign ev_set[`EV_LOADED] = load_q;
    assign ev_set[`EV_SECOND] = sec_wrap;
    assign ev_clr = (wr_fire && aw_addr_q == `OFF_INT_STAT && w_strb_q[0]) ?
                    w_data_q[`EV_W-1:0] : {`EV_W{1'b0}};

    // Counter: load wins over counting; stop simply holds the value
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q    <= {`CNT_W{1'b0}};
            trim_cnt_q <= {`TRIM_W{1'b0}};
            ref_q      <= 1'b0;
        end else begin
            ref_q <= ref_tick_in;
            if (load_q) begin
                count_q    <= {load_sec_q, load_frac_q};
                trim_cnt_q <= {`TRIM_W{1'b0}};
            end else if (en_q && tick) begin
                count_q <= count_d;
                if (trim_hit || !trim_q[`TRIM_EN_BIT]) begin
                    trim_cnt_q <= {`TRIM_W{1'b0}};
                end else begin
                    trim_cnt_q <= trim_cnt_q + {{(`TRIM_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // Register writes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q        <= 1'b0;
            load_q      <= 1'b0;
            alarm_en_q  <= 1'b0;
            load_sec_q  <= {`SEC_W{1'b0}};
            load_frac_q <= {`FRAC_W{1'b0}};
            alarm_q     <= {`SEC_W{1'b0}};
            trim_q      <= 32'h0000_0000;
            mask_q      <= {`EV_W{1'b0}};
            stat_q      <= {`EV_W{1'b0}};
        end else begin
            // Set wins over a write-one clear in the same cycle
            stat_q <= (stat_q & ~ev_clr) | ev_set;
            if (load_q) begin
                load_q <= 1'b0;
            end
            if (wr_fire) begin
                case (aw_addr_q)
                    `OFF_CTRL: begin
                        if (w_strb_q[0]) begin
                            en_q       <= w_data_q[`CTRL_EN_BIT];
                            alarm_en_q <= w_data_q[`CTRL_ALARM_BIT];
                            if (w_data_q[`CTRL_LOAD_BIT]) begin
                                load_q <= 1'b1;
                            end
                        end
                    end
                    `OFF_LOAD_SEC: begin
                        load_sec_q <= (load_sec_q & ~wmask) | (w_data_q & wmask);
                    end
                    `OFF_LOAD_FRAC: begin
                        load_frac_q <= (load_frac_q & ~wmask[`FRAC_W-1:0]) |
                                       (w_data_q[`FRAC_W-1:0] & wmask[`FRAC_W-1:0]);
                    end
                    `OFF_ALARM: begin
                        alarm_q <= (alarm_q & ~wmask) | (w_data_q & wmask);
                    end
                    `OFF_TRIM: begin
                        trim_q <= (trim_q & ~wmask) | (w_data_q & wmask);
                    end
                    `OFF_INT_MASK: begin
                        if (w_strb_q[0]) begin
                            mask_q <= w_data_q[`EV_W-1:0];
                        end
                    end
                    default: begin
                        mask_q <= mask_q;
                    end
                endcase
            end
        end
    end

    // Write address decode for the response code
    always @* begin
        wr_hit = 1'b0;
        case (aw_addr_q)
            `OFF_CTRL, `OFF_SEC, `OFF_FRAC, `OFF_LOAD_SEC, `OFF_LOAD_FRAC,
            `OFF_ALARM, `OFF_TRIM, `OFF_INT_STAT, `OFF_INT_MASK: wr_hit = 1'b1;
            default: wr_hit = (aw_addr_q[`ADDR_W-1:8] == `SRAM_PAGE);
        endcase
    end

    // Read mux; seconds and fraction are separate words
    always @* begin
        reg_rdata = 32'h0000_0000;
        reg_hit   = 1'b1;
        case (ar_addr_q)
            `OFF_CTRL: begin
                reg_rdata[`CTRL_EN_BIT]    = en_q;
                reg_rdata[`CTRL_LOAD_BIT]  = load_q;
                reg_rdata[`CTRL_ALARM_BIT] = alarm_en_q;
            end
            `OFF_SEC:       reg_rdata = count_q[`CNT_W-1:`FRAC_W];
            `OFF_FRAC:      reg_rdata[`FRAC_W-1:0] = count_q[`FRAC_W-1:0];
            `OFF_LOAD_SEC:  reg_rdata = load_sec_q;
            `OFF_LOAD_FRAC: reg_rdata[`FRAC_W-1:0] = load_frac_q;
            `OFF_ALARM:     reg_rdata = alarm_q;
            `OFF_TRIM:      reg_rdata = trim_q;
            `OFF_INT_STAT:  reg_rdata[`EV_W-1:0] = stat_q;
            `OFF_INT_MASK:  reg_rdata[`EV_W-1:0] = mask_q;
            default: begin
                reg_rdata = rd_sram_q ? sram_rdata : 32'h0000_0000;
                reg_hit   = rd_sram_q;
            end
        endcase
    end

    // Write channels: address and data accepted in either order
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= {`ADDR_W{1'b0}};
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q     <= {s_axi_awaddr[`ADDR_W-1:2], 2'h0};
                aw_have_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end else if (!aw_have_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                w_have_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end else if (!w_have_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_fire) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: two cycles so SRAM data can come from its register
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
            rd_busy_q     <= 1'b0;
            ar_addr_q     <= {`ADDR_W{1'b0}};
        end else begin
            if (rd_take) begin
                ar_addr_q     <= {s_axi_araddr[`ADDR_W-1:2], 2'h0};
                rd_busy_q     <= 1'b1;
                s_axi_arready <= 1'b0;
            end else if (rd_busy_q && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= reg_rdata;
                s_axi_rresp  <= reg_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                rd_busy_q    <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!rd_busy_q) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Interrupt and wake outputs; wake ignores the mask so it cannot be lost
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irq  <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq  <= |(stat_q & mask_q);
            wake <= stat_q[`EV_ALARM];
        end
    end

    rtc_sram u_sram (
        .clk     (clk),
        .we      (wr_sram),
        .be      (w_strb_q),
        .waddr   (aw_addr_q[`SRAM_AW+1:2]),
        .wdata   (w_data_q),
        .re      (rd_take),
        .raddr   (s_axi_araddr[`SRAM_AW+1:2]),
        .rdata_q (sram_rdata)
    );
endmodule // rtc_top

`default_nettype wire

// file: rtc_checker.sv
// Purpose: Port-level checks for the seconds clock
// Assumes: Single clk domain, rst asynchronous active high
// Notes:   Read latency of two edges is the designer's fixed answer time
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.vh"

module rtc_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        wake
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // One quiet edge after the take, then the answer on the second edge
    sequence s_rd_wait;
        !s_axi_rvalid ##1 s_axi_rvalid;
    endsequence

    property p_aw_drop;
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
    endproperty
    property p_b_bound;
        s_axi_awvalid && s_axi_awready |-> ##[1:40] s_axi_bvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rd_lat;
        s_ar_take |=> s_rd_wait;
    endproperty
    // Ready may return on the edge after the R handshake, so only two edges are owed
    property p_ar_busy;
        s_ar_take |=> !s_axi_arready [*2];
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_rd_err;
        s_axi_rvalid && s_axi_rresp != `RESP_OKAY |->
            s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
    endproperty
    // Only a register write can clear the sticky alarm request
    property p_wake_sticky;
        wake && !s_axi_bvalid |=> wake;
    endproperty

    a_aw_drop: assert property (p_aw_drop) else $error("awready stayed high");
    a_b_bound: assert property (p_b_bound) else $error("write response missing");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_rd_lat: assert property (p_rd_lat) else $error("read latency wrong");
    a_ar_busy: assert property (p_ar_busy) else $error("second read accepted");
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    a_rd_err: assert property (p_rd_err) else $error("error read bad data");
    a_wake_sticky: assert property (p_wake_sticky) else $error("wake fell alone");
endmodule // rtc_checker

bind rtc_top rtc_checker i_chk (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rresp, .s_axi_rdata, .wake);

`default_nettype wire

// file: testbench.sv
// Purpose: Register-level test of the seconds clock
// Assumes: Reference ticks are driven slowly by the bench
// Notes:   Trim period of one keeps the adjusted counts short
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.vh"

module testbench;
    logic        clk, rst, ref_tick_in;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq, wake;
    logic [1:0]  bresp, rresp, r;
    int          errors, checks_done, m;

    rtc_top i_dut (.clk(clk), .rst(rst), .ref_tick_in(ref_tick_in),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .wake(wake));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic tally_and_finish;
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        rd(a);
        chk(d, exp);
    endtask

    // Sets the load bit together with the given control bits, then polls for completion
    task automatic load(input logic [31:0] c);
        wr(`OFF_CTRL, c | 32'h2, 4'hf);
        for (int i = 0; i < 10; i++) begin
            rd(`OFF_CTRL);
            if (d[`CTRL_LOAD_BIT] === 1'b0) break;
        end
        chk({31'h0, d[`CTRL_LOAD_BIT]}, 32'h0);
    endtask

    // Held high several cycles so the one-clock edge detect cannot miss it
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            ref_tick_in <= 1'b1;
            repeat (3) @(posedge clk);
            ref_tick_in <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        tally_and_finish;
    end

    initial begin
        {rst, ref_tick_in, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
        {awaddr, araddr, wdata, wstrb} = '0;
        errors = 0;
        checks_done = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rc(`OFF_SEC, 32'h0);
        rc(`OFF_FRAC, 32'h0);
        rd(12'h024);
        chk(d, 32'h0);
        chk({30'h0, r}, {30'h0, `RESP_SLVERR});
        wr(12'h030, 32'h1, 4'hf);
        chk({30'h0, r}, {30'h0, `RESP_SLVERR});
        wr(`OFF_LOAD_SEC, 32'h1234_5678, 4'hf);
        wr(`OFF_LOAD_FRAC, 32'hffff_ffff, 4'hf);
        rc(`OFF_LOAD_SEC, 32'h1234_5678);
        rc(`OFF_LOAD_FRAC, 32'h0000_7fff);
        wr(`OFF_LOAD_FRAC, 32'h0000_7ffe, 4'hf);
        load(32'h0);
        rc(`OFF_SEC, 32'h1234_5678);
        rc(`OFF_FRAC, 32'h0000_7ffe);
        rd(`OFF_INT_STAT);
        chk(d & 32'h2, 32'h2);
        wr(`OFF_SEC, 32'h0, 4'hf);
        chk({30'h0, r}, {30'h0, `RESP_OKAY});
        wr(`OFF_CTRL, 32'h1, 4'hf);
        tick(2);
        wr(`OFF_CTRL, 32'h0, 4'hf);
        rc(`OFF_SEC, 32'h1234_5679);
        rc(`OFF_FRAC, 32'h0);
        tick(3);
        rc(`OFF_FRAC, 32'h0);
        wr(`OFF_LOAD_FRAC, 32'h0000_7fff, 4'hf);
        wr(`OFF_LOAD_SEC, 32'h1234_5679, 4'hf);
        wr(`OFF_ALARM, 32'h1234_567a, 4'hf);
        wr(`OFF_INT_STAT, 32'h7, 4'hf);
        wr(`OFF_INT_MASK, 32'h1, 4'hf);
        load(32'h4);
        chk({31'h0, wake}, 32'h0);
        wr(`OFF_CTRL, 32'h5, 4'hf);
        tick(1);
        repeat (3) @(posedge clk);
        chk({31'h0, wake}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(`OFF_INT_MASK, 32'h0, 4'hf);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(`OFF_CTRL, 32'h0, 4'hf);
        wr(`OFF_ALARM, 32'h0, 4'hf);
        repeat (3) @(posedge clk);
        chk({31'h0, wake}, 32'h1);
        wr(`OFF_INT_STAT, 32'h1, 4'hf);
        repeat (3) @(posedge clk);
        chk({31'h0, wake}, 32'h0);
        wr(`OFF_LOAD_SEC, 32'h0, 4'hf);
        wr(`OFF_LOAD_FRAC, 32'h0, 4'hf);
        for (m = 0; m < 2; m++) begin
            wr(`OFF_TRIM, 32'h0001_0001 | (m << `TRIM_SLOW_BIT), 4'hf);
            load(32'h0);
            wr(`OFF_CTRL, 32'h1, 4'hf);
            tick(4);
            wr(`OFF_CTRL, 32'h0, 4'hf);
            rc(`OFF_FRAC, (m == 1) ? 32'h2 : 32'h6);
        end
        wr(12'h100, 32'hdead_beef, 4'hf);
        wr(12'h1fc, 32'h0123_4567, 4'hf);
        wr(12'h1fc, 32'hffff_ffff, 4'h1);
        rc(12'h100, 32'hdead_beef);
        rc(12'h1fc, 32'h0123_45ff);
        tally_and_finish;
    end
endmodule // testbench

`default_nettype wire
